// ---- verilog/sfr_block.v ----
/*
 * Core status word, power control, port 1 mode and calibration registers,
 * with direct-address decode of the special register area and the working
 * register banks. Assumes every input comes from core logic on clk_in and
 * that other peripherals answer reads through ext_rdata_in.
 */
`timescale 1ns/1ns
`include "sfr_consts.vh"
module sfr_block #(
  parameter [7:0] CAL_OFFS_FACTORY = `CAL_OFFS_DEFAULT,  // Factory offset trim.
  parameter [7:0] CAL_GAIN_FACTORY = `CAL_GAIN_DEFAULT   // Factory gain trim.
) (
  input  wire       clk_in,                    // Core clock, 10 MHz.
  input  wire       rst_in,                    // Power-on reset, async, high.
  input  wire [7:0] addr_in,                   // Data address of byte access.
  input  wire       indirect_in,               // Access is indirect.
  input  wire       wr_in,                     // Byte write strobe.
  input  wire       rd_in,                     // Byte read strobe.
  input  wire [7:0] wdata_in,                  // Byte write data.
  output reg  [7:0] rdata_out,                 // Byte read data, 1 cycle late.
  output wire       upper_ram_sel_out,         // Access goes to upper RAM.
  output wire       ext_sfr_sel_out,           // Access goes to another peripheral.
  input  wire [7:0] ext_rdata_in,              // Read data of other peripherals.
  input  wire [7:0] bit_addr_in,               // Bit address, 80H to FFH.
  input  wire       bit_wr_in,                 // Bit write strobe.
  input  wire       bit_rd_in,                 // Bit read strobe.
  input  wire       bit_wdata_in,              // Bit write value.
  output reg        bit_rdata_out,             // Bit read value, 1 cycle late.
  output wire       bit_refused_out,           // Bit access to a bit address below 80H.
  input  wire [7:0] acc_in,                    // Accumulator contents.
  input  wire       flag_wr_in,                // Arithmetic flag update.
  input  wire       carry_in,                  // New carry.
  input  wire       nibble_carry_in,           // New nibble carry.
  input  wire       range_in,                  // New overflow.
  input  wire [2:0] reg_index_in,              // Working register 0 to 7.
  input  wire       reg_wr_in,                 // Working register write.
  input  wire       reg_rd_in,                 // Working register read.
  input  wire [7:0] reg_wdata_in,              // Working register write data.
  output wire [7:0] reg_rdata_out,             // Working register data, 1 cycle late.
  output wire [7:0] bank_base_out,             // Base address of selected bank.
  output wire [7:0] status_word_out,           // Whole status word.
  output wire       baud_doubler_out,          // Double serial baud rate.
  output wire       serial_wake_enable_out,    // Serial wake-up enable.
  output wire       ext_irq0_wake_enable_out,  // External irq 0 wake-up enable.
  output wire       latch_strobe_disable_out,  // Address-latch strobe off.
  output wire       deep_sleep_enable_out,     // Power-down request.
  output wire       core_halt_enable_out,      // Idle request.
  output wire [7:0] port1_digital_en_out,      // Digital function per port 1 pin.
  output wire [7:0] cal_offset_out,            // Converter offset trim.
  output wire [7:0] cal_gain_out               // Converter gain trim.
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers.

  function is_bit_addressable;
    input [7:0] a;
    begin
      is_bit_addressable = a[`SFR_AREA_BIT] & (a[2:0] == `BIT_AREA_LOW);
    end
  endfunction

  function [7:0] set_bit;
    input [7:0] value;
    input [2:0] pos;
    input       b;
    reg   [7:0] tmp;
    begin
      tmp      = value;
      tmp[pos] = b;
      set_bit  = tmp;
    end
  endfunction

  reg  [7:0] cpu_status_word;
  reg  [7:0] power_control;
  reg  [7:0] port1_mode;
  reg  [7:0] cal_offset;
  reg  [7:0] cal_gain;
  reg  [7:0] next_status;
  reg  [7:0] next_power;
  reg  [7:0] next_port1;
  reg  [7:0] byte_view;
  reg  [7:0] bit_byte_view;

  wire       sfr_access;
  wire       hit_status;
  wire       hit_power;
  wire       hit_port1;
  wire       hit_offs;
  wire       hit_gain;
  wire       own_hit;
  wire [7:0] bit_byte_addr;
  wire       bit_ok;
  wire       bit_wr_ok;
  wire [1:0] bank;

  // Direct addresses in the upper half are special registers; indirect ones
  // there reach upper RAM instead, so the two never collide.
  assign sfr_access        = addr_in[`SFR_AREA_BIT] & ~indirect_in;
  assign upper_ram_sel_out = (wr_in | rd_in) & addr_in[`SFR_AREA_BIT]
                             & indirect_in;
  assign hit_status = sfr_access & (addr_in == `STATUS_ADDR);
  assign hit_power  = sfr_access & (addr_in == `POWER_ADDR);
  assign hit_port1  = sfr_access & (addr_in == `PORT1_ADDR);
  assign hit_offs   = sfr_access & (addr_in == `CAL_OFFS_ADDR);
  assign hit_gain   = sfr_access & (addr_in == `CAL_GAIN_ADDR);
  assign own_hit    = hit_status | hit_power | hit_port1 | hit_offs | hit_gain;
  // Every other special register, including test and unoccupied slots, is
  // handed to the rest of the chip; this block stores nothing for them.
  assign ext_sfr_sel_out = (wr_in | rd_in) & sfr_access & ~own_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Bit access: the byte address is the bit address with its low three bits
  // cleared, so only addresses ending in 0H or 8H can ever be reached.

  assign bit_byte_addr   = {bit_addr_in[7:3], `BIT_AREA_LOW};
  assign bit_ok          = is_bit_addressable(bit_byte_addr);
  assign bit_wr_ok       = bit_wr_in & bit_ok;
  assign bit_refused_out = (bit_wr_in | bit_rd_in) & ~bit_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Next register values. Byte write first, then bit write, then the
  // arithmetic flag update, so the core's own result is never lost.

  always @* begin
    next_status = cpu_status_word;
    next_power  = power_control;
    next_port1  = port1_mode;
    if (wr_in & hit_status) begin
      next_status = wdata_in;
    end
    if (bit_wr_ok & (bit_byte_addr == `STATUS_ADDR)) begin
      next_status = set_bit(next_status, bit_addr_in[2:0], bit_wdata_in);
    end
    if (flag_wr_in) begin
      next_status[`STATUS_CARRY]  = carry_in;
      next_status[`STATUS_NIBBLE] = nibble_carry_in;
      next_status[`STATUS_RANGE]  = range_in;
    end
    // Parity is rebuilt from the accumulator, so writes to it have no effect.
    next_status[`STATUS_PARITY] = ^acc_in;
    if (wr_in & hit_power) begin
      next_power = wdata_in;
    end
    if (wr_in & hit_port1) begin
      next_port1 = wdata_in;
    end
    if (bit_wr_ok & (bit_byte_addr == `PORT1_ADDR)) begin
      next_port1 = set_bit(next_port1, bit_addr_in[2:0], bit_wdata_in);
    end
  end

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cpu_status_word <= `STATUS_RESET;
      power_control   <= `POWER_RESET;
      port1_mode      <= `PORT1_RESET;
      cal_offset      <= CAL_OFFS_FACTORY;
      cal_gain        <= CAL_GAIN_FACTORY;
    end else begin
      cpu_status_word <= next_status;
      power_control   <= next_power;
      port1_mode      <= next_port1;
      if (wr_in & hit_offs) begin
        cal_offset <= wdata_in;
      end
      if (wr_in & hit_gain) begin
        cal_gain <= wdata_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read paths, one cycle of latency for both byte and bit reads.

  always @* begin
    case (1'b1)
      hit_status: byte_view = cpu_status_word;
      hit_power:  byte_view = power_control;
      hit_port1:  byte_view = port1_mode;
      hit_offs:   byte_view = cal_offset;
      hit_gain:   byte_view = cal_gain;
      default:    byte_view = ext_rdata_in;
    endcase
  end

  always @* begin
    case (bit_byte_addr)
      `STATUS_ADDR: bit_byte_view = cpu_status_word;
      `PORT1_ADDR:  bit_byte_view = port1_mode;
      default:      bit_byte_view = ext_rdata_in;
    endcase
  end

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out     <= `ZERO_BYTE;
      bit_rdata_out <= 1'b0;
    end else begin
      if (rd_in) begin
        rdata_out <= byte_view;
      end
      if (bit_rd_in) begin
        bit_rdata_out <= bit_ok & bit_byte_view[bit_addr_in[2:0]];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Working registers and control outputs.

  assign bank = {cpu_status_word[`STATUS_BANK_HI], cpu_status_word[`STATUS_BANK_LO]};
  assign bank_base_out = {6'h00, bank} << `BANK_SHIFT;

  work_reg_ram u_work_regs (
    .clk_in    (clk_in),
    .wr_in     (reg_wr_in),
    .rd_in     (reg_rd_in),
    .addr_in   ({bank, reg_index_in}),
    .wdata_in  (reg_wdata_in),
    .rdata_out (reg_rdata_out)
  );

  assign status_word_out          = cpu_status_word;
  assign baud_doubler_out         = power_control[`POWER_BAUD];
  assign serial_wake_enable_out   = power_control[`POWER_SER_WAKE];
  assign ext_irq0_wake_enable_out = power_control[`POWER_IRQ0_WAKE];
  assign latch_strobe_disable_out = power_control[`POWER_STROBE_OFF];
  assign deep_sleep_enable_out    = power_control[`POWER_DEEP];
  assign core_halt_enable_out     = power_control[`POWER_HALT];
  // A port 1 pin is analog while its bit is 1, which it is from reset.
  assign port1_digital_en_out     = ~port1_mode;
  assign cal_offset_out           = cal_offset;
  assign cal_gain_out             = cal_gain;

endmodule

// ---- verilog/sfr_consts.vh ----
/*
 * Constants for the core status and power control register block: direct
 * addresses, reset values, field positions and the working register layout.
 * Assumes it is included by bare name from the design files that need it.
 */
//
// Functional notes
// - The status word sits at direct address D0H, resets to 00H and holds carry, nibble carry, two user flags, bank select, range flag and parity.
// - Status bits 4 and 3 form a binary bank number 0 to 3 that picks the working register bank.
// - The power control register at 87H resets to 00H, is not bit addressable, and holds baud doubling, two wake enables, strobe disable, two spare flags, deep sleep and halt.
// - Every register other than the program counter and the working register banks lives in the special register area.
// - Unoccupied special register addresses hold no storage and may read back any value.
// - Single-bit access works only on special registers whose address ends in 0H or 8H.
// - Port 1 pins start as analog inputs and a pin's digital function is enabled only once software writes 0 to its port 1 bit.
// - At power-up the converter calibration registers load factory values, not zero.
// - The four banks of eight working registers fill the lowest 32 bytes of internal data memory, with the bank number fixing the base.
// - The special register area is reached only by direct addressing; indirect accesses there go to the upper 128 bytes of RAM.
`ifndef SFR_CONSTS_VH
`define SFR_CONSTS_VH

`define STATUS_ADDR     8'hD0
`define POWER_ADDR      8'h87
`define PORT1_ADDR      8'h90
`define CAL_OFFS_ADDR   8'hF3
`define CAL_GAIN_ADDR   8'hF4

`define STATUS_RESET    8'h00
`define POWER_RESET     8'h00
`define PORT1_RESET     8'hFF
`define CAL_OFFS_DEFAULT 8'h80
`define CAL_GAIN_DEFAULT 8'h80

`define STATUS_CARRY    7
`define STATUS_NIBBLE   6
`define STATUS_USER0    5
`define STATUS_BANK_HI  4
`define STATUS_BANK_LO  3
`define STATUS_RANGE    2
`define STATUS_USER1    1
`define STATUS_PARITY   0

`define POWER_BAUD       7
`define POWER_SER_WAKE   6
`define POWER_IRQ0_WAKE  5
`define POWER_STROBE_OFF 4
`define POWER_DEEP       1
`define POWER_HALT       0

`define SFR_AREA_BIT    7
`define BIT_AREA_LOW    3'h0
`define ZERO_BYTE       8'h00
`define BANK_SHIFT      3

`endif

// ---- verilog/work_reg_ram.v ----
/*
 * Working register store: four banks of eight bytes, the lowest 32 bytes of
 * internal data memory. Read data come out of a register one cycle after the
 * read strobe. Assumes a single clock shared with the core.
 */
`timescale 1ns/1ns
module work_reg_ram (
  input  wire       clk_in,     // Core clock.
  input  wire       wr_in,      // Write strobe.
  input  wire       rd_in,      // Read strobe.
  input  wire [4:0] addr_in,    // Byte address 00H to 1FH.
  input  wire [7:0] wdata_in,   // Write data.
  output reg  [7:0] rdata_out   // Registered read data.
);

  reg [7:0] mem [0:31];

  // No reset on the array: working registers power up undefined, as in RAM.
  always @(posedge clk_in) begin
    if (wr_in) begin
      mem[addr_in] <= wdata_in;
    end
    if (rd_in) begin
      rdata_out <= mem[addr_in];
    end
  end

endmodule

// ---- verification/sfr_block_sva.sv ----
/* Checker for the status word, power control and decode ports of sfr_block.
   Assumes one core clock and the asynchronous active-high reset of the block. */
`timescale 1ns/1ns
module sfr_block_sva (
  input wire       clk_in, rst_in, indirect_in, wr_in, rd_in, bit_wr_in, bit_rd_in,
  input wire       bit_wdata_in, flag_wr_in, upper_ram_sel_out, ext_sfr_sel_out,
  input wire       bit_rdata_out, bit_refused_out, baud_doubler_out, serial_wake_enable_out,
  input wire       ext_irq0_wake_enable_out, latch_strobe_disable_out,
  input wire       deep_sleep_enable_out, core_halt_enable_out,
  input wire [7:0] addr_in, wdata_in, rdata_out, ext_rdata_in, bit_addr_in, acc_in,
  input wire [7:0] bank_base_out, status_word_out
);
  wire [5:0] power_vis = {baud_doubler_out, serial_wake_enable_out, ext_irq0_wake_enable_out,
                          latch_strobe_disable_out, deep_sleep_enable_out, core_halt_enable_out};
  function [5:0] pick(input [7:0] v);
    pick = {v[7:4], v[1:0]};
  endfunction
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  ////////////////////////////////////////////////////////////////////////////////
  property p_bank_base; bank_base_out == {3'h0, status_word_out[4:3], 3'h0}; endproperty
  a_bank_base: assert property (p_bank_base) else $error("bank base wrong");
  // The first edge after release still sees the reset value, so it is skipped.
  property p_parity; !$past(rst_in) |-> status_word_out[0] == ^$past(acc_in); endproperty
  a_parity: assert property (p_parity) else $error("parity bit wrong");
  property p_status_read; rd_in && !indirect_in && addr_in == 8'hD0
    |=> rdata_out == $past(status_word_out); endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");
  property p_power_write; wr_in && !indirect_in && addr_in == 8'h87
    |=> power_vis == pick($past(wdata_in)); endproperty
  a_power_write: assert property (p_power_write) else $error("power write wrong");
  property p_power_read; rd_in && !indirect_in && addr_in == 8'h87
    |=> pick(rdata_out) == $past(power_vis); endproperty
  a_power_read: assert property (p_power_read) else $error("power read wrong");
  property p_upper; upper_ram_sel_out == ((wr_in || rd_in) && addr_in[7] && indirect_in);
  endproperty
  a_upper: assert property (p_upper) else $error("upper ram select wrong");
  property p_refuse; bit_refused_out == ((bit_wr_in || bit_rd_in) && !bit_addr_in[7]);
  endproperty
  a_refuse: assert property (p_refuse) else $error("bit refusal wrong");
  property p_refused_zero; bit_rd_in && !bit_addr_in[7] |=> !bit_rdata_out; endproperty
  a_refused_zero: assert property (p_refused_zero) else $error("refused bit read");
  property p_ext_read; rd_in && ext_sfr_sel_out |=> rdata_out == $past(ext_rdata_in);
  endproperty
  a_ext_read: assert property (p_ext_read) else $error("unoccupied read wrong");
  property p_carry_bit; bit_wr_in && bit_addr_in == 8'hD7 && !wr_in && !flag_wr_in
    |=> status_word_out[7] == $past(bit_wdata_in); endproperty
  a_carry_bit: assert property (p_carry_bit) else $error("carry bit write wrong");
  c_power_write: cover property (wr_in && addr_in == 8'h87);
  c_refused: cover property (bit_refused_out);
  c_upper: cover property (upper_ram_sel_out);
endmodule
bind sfr_block sfr_block_sva chk (.clk_in(clk_in), .rst_in(rst_in), .indirect_in(indirect_in),
  .wr_in(wr_in), .rd_in(rd_in), .bit_wr_in(bit_wr_in), .bit_rd_in(bit_rd_in),
  .bit_wdata_in(bit_wdata_in), .flag_wr_in(flag_wr_in), .upper_ram_sel_out(upper_ram_sel_out),
  .ext_sfr_sel_out(ext_sfr_sel_out), .bit_rdata_out(bit_rdata_out),
  .bit_refused_out(bit_refused_out), .baud_doubler_out(baud_doubler_out),
  .serial_wake_enable_out(serial_wake_enable_out),
  .ext_irq0_wake_enable_out(ext_irq0_wake_enable_out),
  .latch_strobe_disable_out(latch_strobe_disable_out),
  .deep_sleep_enable_out(deep_sleep_enable_out), .core_halt_enable_out(core_halt_enable_out),
  .addr_in(addr_in), .wdata_in(wdata_in), .rdata_out(rdata_out), .ext_rdata_in(ext_rdata_in),
  .bit_addr_in(bit_addr_in), .acc_in(acc_in), .bank_base_out(bank_base_out),
  .status_word_out(status_word_out));

// ---- verification/cpu_status_power_sfr_map_tb.sv ----
/* Self-checking bench for sfr_block, driving every port directly.
   Assumes the bound checker and a 10 MHz core clock. */
`timescale 1ns/1ns
module cpu_status_power_sfr_map_tb;
  localparam [7:0] OFFS = 8'h5A;
  localparam [7:0] GAIN = 8'hC3;
  reg        clk_in = 1'b0;
  reg        rst_in = 1'b1;
  reg  [7:0] addr_in = 8'h00, wdata_in = 8'h00, ext_rdata_in = 8'h00, bit_addr_in = 8'h00;
  reg  [7:0] acc_in = 8'h00, reg_wdata_in = 8'h00, q;
  reg        indirect_in = 0, wr_in = 0, rd_in = 0, bit_wr_in = 0, bit_rd_in = 0;
  reg        bit_wdata_in = 0, flag_wr_in = 0, carry_in = 0, nibble_carry_in = 0, range_in = 0;
  reg        reg_wr_in = 0, reg_rd_in = 0, s1, s2;
  reg  [2:0] reg_index_in = 3'h0;
  wire [7:0] rdata_out, reg_rdata_out, bank_base_out, status_word_out, port1_digital_en_out;
  wire [7:0] cal_offset_out, cal_gain_out;
  wire       upper_ram_sel_out, ext_sfr_sel_out, bit_rdata_out, bit_refused_out, baud, ser;
  wire       irq0, ale, deep, halt;
  wire [7:0] power_vis = {baud, ser, irq0, ale, 2'h0, deep, halt};
  integer    err_count = 0;
  integer    comparisons = 0;
  always #50 clk_in = ~clk_in;
  sfr_block #(.CAL_OFFS_FACTORY(OFFS), .CAL_GAIN_FACTORY(GAIN)) uut (.clk_in(clk_in),
    .rst_in(rst_in), .addr_in(addr_in), .indirect_in(indirect_in), .wr_in(wr_in),
    .rd_in(rd_in), .wdata_in(wdata_in), .rdata_out(rdata_out),
    .upper_ram_sel_out(upper_ram_sel_out), .ext_sfr_sel_out(ext_sfr_sel_out),
    .ext_rdata_in(ext_rdata_in), .bit_addr_in(bit_addr_in), .bit_wr_in(bit_wr_in),
    .bit_rd_in(bit_rd_in), .bit_wdata_in(bit_wdata_in), .bit_rdata_out(bit_rdata_out),
    .bit_refused_out(bit_refused_out), .acc_in(acc_in), .flag_wr_in(flag_wr_in),
    .carry_in(carry_in), .nibble_carry_in(nibble_carry_in), .range_in(range_in),
    .reg_index_in(reg_index_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .bank_base_out(bank_base_out),
    .status_word_out(status_word_out), .baud_doubler_out(baud), .serial_wake_enable_out(ser),
    .ext_irq0_wake_enable_out(irq0), .latch_strobe_disable_out(ale),
    .deep_sleep_enable_out(deep), .core_halt_enable_out(halt),
    .port1_digital_en_out(port1_digital_en_out), .cal_offset_out(cal_offset_out),
    .cal_gain_out(cal_gain_out));
  ////////////////////////////////////////////////////////////////////////////////
  task tick; begin
    @(posedge clk_in);
    #10;
  end endtask
  task cmp(input [8*12-1:0] what, input [7:0] exp, input [7:0] got); begin
    comparisons = comparisons + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("MISMATCH %0s expected %h seen %h", what, exp, got);
    end
  end endtask
  // Strobes are lowered and an idle cycle follows, so calls may run back to back.
  task byte_acc(input w, input ind, input [7:0] a, input [7:0] d); begin
    addr_in = a; indirect_in = ind; wdata_in = d; wr_in = w; rd_in = !w;
    #1; s1 = upper_ram_sel_out; s2 = ext_sfr_sel_out;
    tick; wr_in = 0; rd_in = 0; indirect_in = 0; q = rdata_out; tick;
  end endtask
  task bit_acc(input w, input [7:0] a, input v); begin
    bit_addr_in = a; bit_wdata_in = v; bit_wr_in = w; bit_rd_in = !w;
    #1; s1 = bit_refused_out;
    tick; bit_wr_in = 0; bit_rd_in = 0; q = {7'h0, bit_rdata_out}; tick;
  end endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_reset; begin
    cmp("status", 8'h00, status_word_out);
    cmp("power", 8'h00, power_vis);
    cmp("port1 en", 8'h00, port1_digital_en_out);
    cmp("cal offset", OFFS, cal_offset_out);
    cmp("cal gain", GAIN, cal_gain_out);
    byte_acc(0, 0, 8'h87, 8'h00);
    cmp("power read", 8'h00, q);
    $display("test reset done");
  end endtask
  task t_status; begin
    byte_acc(1, 0, 8'hD0, 8'hE6);
    cmp("status", 8'hE6, status_word_out);
    byte_acc(1, 0, 8'hD0, 8'h01);
    cmp("status", 8'h00, status_word_out);
    acc_in = 8'h07;
    tick;
    cmp("status", 8'h01, status_word_out);
    byte_acc(0, 0, 8'hD0, 8'h00);
    cmp("status read", 8'h01, q);
    acc_in = 8'h00;
    byte_acc(1, 0, 8'hD0, 8'h00);
    $display("test status done");
  end endtask
  task t_power_control; begin
    byte_acc(1, 0, 8'h87, 8'hFF);
    cmp("power", 8'hF3, power_vis);
    byte_acc(0, 0, 8'h87, 8'h00);
    cmp("power read", 8'hFF, q);
    bit_acc(1, 8'h87, 1'b0);
    byte_acc(0, 0, 8'h87, 8'h00);
    cmp("power read", 8'hFF, q);
    byte_acc(1, 0, 8'h87, 8'h0C);
    cmp("power", 8'h00, power_vis);
    $display("test power done");
  end endtask
  task t_bank;
    integer b;
    begin
    for (b = 0; b < 4; b = b + 1) begin
      byte_acc(1, 0, 8'hD0, {3'h0, b[1:0], 3'h0});
      cmp("bank base", {3'h0, b[1:0], 3'h0}, bank_base_out);
      reg_index_in = 3'h5; reg_wdata_in = {6'h28, b[1:0]}; reg_wr_in = 1;
      tick; reg_wr_in = 0; tick;
    end
    for (b = 0; b < 4; b = b + 1) begin
      byte_acc(1, 0, 8'hD0, {3'h0, b[1:0], 3'h0});
      reg_rd_in = 1;
      tick; reg_rd_in = 0;
      cmp("work reg", {6'h28, b[1:0]}, reg_rdata_out);
    end
    $display("test bank done");
  end endtask
  task t_bits; begin
    bit_acc(1, 8'hD7, 1'b1);
    cmp("carry", 8'h01, {7'h0, status_word_out[7]});
    // The carry read leaves a 1 behind, so a refused read that kept it would show.
    bit_acc(0, 8'hD7, 1'b0);
    cmp("carry read", 8'h01, q);
    bit_acc(1, 8'h50, 1'b1);
    cmp("bit refused", 8'h01, {7'h0, s1});
    bit_acc(0, 8'h50, 1'b0);
    cmp("refused rd", 8'h00, q);
    bit_acc(1, 8'h90, 1'b0);
    cmp("port1 en", 8'h01, port1_digital_en_out);
    $display("test bits done");
  end endtask
  task t_route; begin
    ext_rdata_in = 8'h3C;
    byte_acc(1, 1, 8'hD0, 8'h55);
    cmp("upper sel", 8'h01, {7'h0, s1});
    cmp("ext sel", 8'h00, {7'h0, s2});
    cmp("status", 8'h98, status_word_out);
    byte_acc(0, 0, 8'hA1, 8'h00); // Stimulus stays clear of test-reserved slots.
    cmp("ext sel", 8'h01, {7'h0, s2});
    cmp("unused read", 8'h3C, q);
    byte_acc(1, 0, 8'hF3, 8'h11);
    cmp("cal offset", 8'h11, cal_offset_out);
    byte_acc(0, 0, 8'hF4, 8'h00);
    cmp("cal read", GAIN, q);
    byte_acc(0, 0, 8'h90, 8'h00);
    cmp("port1 read", 8'hFE, q);
    $display("test route done");
  end endtask
  // The core's flag update and a software write land on the same edge.
  task t_flags; begin
    addr_in = 8'hD0;
    wdata_in = 8'h00;
    wr_in = 1;
    flag_wr_in = 1;
    carry_in = 1;
    nibble_carry_in = 1;
    range_in = 1;
    tick;
    wr_in = 0;
    flag_wr_in = 0;
    tick;
    cmp("flags", 8'hC4, status_word_out);
    $display("test flags done");
  end endtask
  task tally_and_finish; begin
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end endtask
  initial begin
    repeat (4) @(posedge clk_in);
    #10;
    rst_in = 0;
    t_reset; t_status; t_power_control; t_bank; t_bits; t_route; t_flags;
    tally_and_finish;
  end
  // About thirteen times the length of the whole sequence.
  initial begin
    #100000;
    err_count = err_count + 1;
    $display("watchdog expired");
    tally_and_finish;
  end
endmodule
